// *** core/ets_map.svh ***
// Timing counts and time base encodings for the elapsed-time stopwatch.
`ifndef ETS_MAP_SVH
`define ETS_MAP_SVH
`define ETS_CLK_PERIOD_PS    4000
`define ETS_TICK_TIME_MS     10
`define ETS_TICK_CYCLES      ((`ETS_TICK_TIME_MS * 1000000) / (`ETS_CLK_PERIOD_PS / 1000))
`define ETS_TICKS_PER_SEC    100
`define ETS_TICKS_PER_MIN    6000
`define ETS_TICKS_PER_HOUR   360000
`define ETS_BASE_HUNDREDTHS  2'h0
`define ETS_BASE_SECONDS     2'h1
`define ETS_BASE_MINUTES     2'h2
`define ETS_BASE_HOURS       2'h3
`endif

// *** core/ets_pkg.sv ***
// Types shared by the elapsed-time stopwatch.
package ets_pkg;
    typedef enum logic [1:0] {
        ETS_HUNDREDTHS = 2'b00,
        ETS_SECONDS    = 2'b01,
        ETS_MINUTES    = 2'b10,
        ETS_HOURS      = 2'b11
    } ets_base_t;
endpackage

// *** core/ets_stopwatch.sv ***
// Elapsed-time stopwatch with lap hold, clear and selectable time base.
`timescale 1ns/100ps
`include "ets_map.svh"
// Behaviour
// - Run gate rising edge zeroes elapsed count, then counting starts.
// - Run gate falling edge stops counting and holds the elapsed count.
// - While run gate is high the count rises every ten millisecond tick.
// - Split-hold rising edge captures lap time and shows it on output.
// - Split-hold falling edge returns output to current elapsed count.
// - Run high, split high: count keeps advancing, output shows lap.
// - Run low, split high: output shows the held lap value.
// - Run low, split low: output shows the last frozen elapsed count.
// - Clear held high zeroes both elapsed count and lap value.
// - Time base selects hours, minutes, seconds or hundredths.
// - Finest resolution is ten milliseconds per count.
module ets_stopwatch #(
    parameter int TICK_CYCLES = `ETS_TICK_CYCLES,
    parameter int WIDTH       = 32
) (
    // Clock and reset
    input  wire logic             CLOCK_IN,
    input  wire logic             RST_N_IN,
    // Control from other logic
    input  wire logic             RUN_IN,
    input  wire logic             SPLIT_IN,
    input  wire logic             CLEAR_IN,
    input  wire ets_pkg::ets_base_t BASE_IN,
    // Value
    output logic [WIDTH-1:0]      ELAPSED_VALUE_OUT
);
    import ets_pkg::*;

    logic [31:0]      div_reg;
    logic             tick_reg;
    logic             run_q_reg;
    logic             split_q_reg;
    logic [WIDTH-1:0] elapsed_reg;
    logic [WIDTH-1:0] lap_reg;
    logic             show_lap_reg;
    logic             run_rise;
    logic             run_fall;
    logic             split_rise;
    logic             split_fall;
    logic [WIDTH-1:0] shown;
    logic [31:0]      gap_reg;

    function automatic logic [WIDTH-1:0] scale(input logic [WIDTH-1:0] t,
                                               input ets_base_t b);
        case (b)
            ETS_HUNDREDTHS: scale = t;
            ETS_SECONDS:    scale = t / WIDTH'(`ETS_TICKS_PER_SEC);
            ETS_MINUTES:    scale = t / WIDTH'(`ETS_TICKS_PER_MIN);
            ETS_HOURS:      scale = t / WIDTH'(`ETS_TICKS_PER_HOUR);
            default:        scale = t;
        endcase
    endfunction

    // ==========================================================
    // Edge detection.
    assign run_rise   = RUN_IN & ~run_q_reg;
    assign run_fall   = ~RUN_IN & run_q_reg;
    assign split_rise = SPLIT_IN & ~split_q_reg;
    assign split_fall = ~SPLIT_IN & split_q_reg;

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            run_q_reg   <= 1'b0;
            split_q_reg <= 1'b0;
        end else begin
            run_q_reg   <= RUN_IN;
            split_q_reg <= SPLIT_IN;
        end
    end

    // ==========================================================
    // Ten millisecond tick divider.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            div_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end else if (run_rise || !RUN_IN) begin
            div_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
            div_reg  <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Elapsed count.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            elapsed_reg <= '0;
        end else if (CLEAR_IN) begin
            elapsed_reg <= '0;
        end else if (run_rise) begin
            elapsed_reg <= '0;
        end else if (RUN_IN && tick_reg) begin
            elapsed_reg <= elapsed_reg + WIDTH'(1);
        end
    end
    // Counting stops when the run gate is low, holding the count.

    // ==========================================================
    // Lap capture and output selection.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            lap_reg      <= '0;
            show_lap_reg <= 1'b0;
        end else begin
            if (CLEAR_IN) begin
                lap_reg <= '0;
            end else if (split_rise) begin
                lap_reg <= elapsed_reg;
            end
            if (split_rise) begin
                show_lap_reg <= 1'b1;
            end else if (split_fall) begin
                show_lap_reg <= 1'b0;
            end
        end
    end

    assign shown = show_lap_reg ? lap_reg : elapsed_reg;

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ELAPSED_VALUE_OUT <= '0;
        end else begin
            ELAPSED_VALUE_OUT <= scale(shown, BASE_IN);
        end
    end

    // ==========================================================
    // Cycles since the last tick, kept apart from the divider.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            gap_reg <= '1;
        end else if (run_rise || !RUN_IN) begin
            gap_reg <= '1;
        end else if (tick_reg) begin
            gap_reg <= 32'h0;
        end else begin
            gap_reg <= gap_reg + 32'h1;
        end
    end

    // ==========================================================
    // Assertions.
    a_run_rise_zero: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        run_rise |=> elapsed_reg == '0)
        else $error("Elapsed count not zeroed on run start.");
    a_run_low_hold: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (!RUN_IN && !run_rise && !CLEAR_IN) |=> $stable(elapsed_reg))
        else $error("Elapsed count moved while run gate low.");
    a_tick_count: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (RUN_IN && tick_reg && !CLEAR_IN && !run_rise) |=>
            elapsed_reg == $past(elapsed_reg) + WIDTH'(1))
        else $error("Elapsed count did not advance on tick.");
    a_lap_capture: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (split_rise && !CLEAR_IN) |=> lap_reg == $past(elapsed_reg) && show_lap_reg)
        else $error("Lap not captured on split rise.");
    a_split_release: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        split_fall |=> !show_lap_reg ##1 ELAPSED_VALUE_OUT == scale($past(elapsed_reg), $past(BASE_IN)))
        else $error("Output did not return to elapsed count.");
    a_lap_shown: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        show_lap_reg |=> ELAPSED_VALUE_OUT == scale($past(lap_reg), $past(BASE_IN)))
        else $error("Output does not show lap value.");
    a_elapsed_shown: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !show_lap_reg |=> ELAPSED_VALUE_OUT == scale($past(elapsed_reg), $past(BASE_IN)))
        else $error("Output does not show elapsed count.");
    a_clear_zero: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        CLEAR_IN |=> elapsed_reg == '0 && lap_reg == '0)
        else $error("Clear did not zero the counts.");
    a_tick_period: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        tick_reg |=> !tick_reg)
        else $error("Tick pulse longer than one cycle.");
    a_tick_spacing: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        tick_reg |-> gap_reg == 32'(TICK_CYCLES - 1))
        else $error("Tick came at the wrong spacing.");
    a_tick_due: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (RUN_IN && !run_rise && gap_reg == 32'(TICK_CYCLES - 1)) |-> tick_reg)
        else $error("Tick missing when due.");
    a_run_fall_hold: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (run_fall && !CLEAR_IN) |=> $stable(elapsed_reg))
        else $error("Elapsed count moved on run stop.");
    a_run_rise_div: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        run_rise |=> div_reg == 32'h0 && !tick_reg)
        else $error("Divider not restarted on run start.");
    a_lap_stable: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (!CLEAR_IN && !split_rise) |=> $stable(lap_reg))
        else $error("Lap value changed without capture.");
    a_lap_stopped: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (show_lap_reg && !RUN_IN) |=> ELAPSED_VALUE_OUT == scale($past(lap_reg), $past(BASE_IN)))
        else $error("Lap not shown while stopped.");
    a_edge_run: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(RUN_IN) |-> run_rise)
        else $error("Run gate edge missed.");
    a_edge_split: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(SPLIT_IN) |-> split_rise)
        else $error("Split-hold edge missed.");
    a_clear_out: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (CLEAR_IN ##1 CLEAR_IN) |=> ELAPSED_VALUE_OUT == '0)
        else $error("Output not zero under clear.");
    a_base_hundredths: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (BASE_IN == ETS_HUNDREDTHS && !show_lap_reg) |=> ELAPSED_VALUE_OUT == $past(elapsed_reg))
        else $error("Hundredths output wrong.");
    a_base_seconds: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (BASE_IN == ETS_SECONDS && !show_lap_reg) |=>
            ELAPSED_VALUE_OUT == $past(elapsed_reg) / WIDTH'(`ETS_TICKS_PER_SEC))
        else $error("Seconds output wrong.");
    a_base_minutes: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (BASE_IN == ETS_MINUTES && !show_lap_reg) |=>
            ELAPSED_VALUE_OUT == $past(elapsed_reg) / WIDTH'(`ETS_TICKS_PER_MIN))
        else $error("Minutes output wrong.");

    c_run_tick: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        RUN_IN && tick_reg);
    c_lap_while_run: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        RUN_IN && split_rise);
    c_clear: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        CLEAR_IN && elapsed_reg != '0);
    c_split_release: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        RUN_IN && split_fall);
    c_run_stop: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        run_fall && elapsed_reg != '0);
endmodule

// *** test/elapsed_time_stopwatch_tb_top.sv ***
// Self-checking bench for the elapsed-time stopwatch.
`timescale 1ns/100ps
`include "ets_map.svh"
module elapsed_time_stopwatch_tb_top;
    import ets_pkg::*;
    localparam int TICKS = 4;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        run_w    = 1'b0;
    logic        split_w  = 1'b0;
    logic        clear_w  = 1'b0;
    ets_base_t   base_w   = ETS_HUNDREDTHS;
    logic        run, split, clear;
    ets_base_t   base;
    logic [31:0] value, held;
    logic [31:0] lfsr     = 32'h73e1;
    int          n;
    int          mismatches  = 0;
    int          check_count = 0;
    always #2 clock_in = ~clock_in;
    ets_ctrl_model ctrl (.clock_in(clock_in), .run_in(run_w), .split_in(split_w),
        .clear_in(clear_w), .base_in(base_w), .run_out(run), .split_out(split),
        .clear_out(clear), .base_out(base));
    ets_stopwatch #(.TICK_CYCLES(TICKS), .WIDTH(32)) dut (.CLOCK_IN(clock_in),
        .RST_N_IN(rst_n_in), .RUN_IN(run), .SPLIT_IN(split), .CLEAR_IN(clear),
        .BASE_IN(base), .ELAPSED_VALUE_OUT(value));
    // ==========================================
    // Helpers.
    function automatic logic [31:0] scaled(input logic [31:0] t, input ets_base_t b);
        case (b)
            ETS_SECONDS: return t / `ETS_TICKS_PER_SEC;
            ETS_MINUTES: return t / `ETS_TICKS_PER_MIN;
            ETS_HOURS:   return t / `ETS_TICKS_PER_HOUR;
            default:     return t;
        endcase
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic near(input logic [31:0] a, input logic [31:0] e);
        return (a + 32'h1 >= e) && (a <= e + 32'h1);
    endfunction
    task automatic step(input int k);
        repeat (k) @(negedge clock_in);
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic run_for(input int k);
        run_w <= 1'b1;
        step(4);
        check(value === 32'h0, "count not zeroed at start");
        step(k - 4);
        run_w <= 1'b0;
        step(6);
    endtask
    task automatic finish_test();
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios.
    initial begin
        repeat (6) @(posedge clock_in);
        @(negedge clock_in) rst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            n = 8 + lfsr[6:0];
            run_for(n);
            check(near(value, n / TICKS), "elapsed count wrong");
            held = value;
            step(lfsr[3:0] + 2);
            check(value === held, "count not frozen");
        end
        run_w <= 1'b1;
        step(40);
        split_w <= 1'b1;
        step(4);
        held = value;
        check(near(held, 10), "lap not captured");
        step(30);
        check(value === held, "lap not held while running");
        split_w <= 1'b0;
        step(4);
        check(near(value, 19), "output not back to elapsed");
        split_w <= 1'b1;
        run_w <= 1'b0;
        step(4);
        held = value;
        step(10);
        check(value === held, "lap not shown while stopped");
        clear_w <= 1'b1;
        step(4);
        check(value === 32'h0, "lap not cleared");
        split_w <= 1'b0;
        step(4);
        check(value === 32'h0, "elapsed not cleared");
        clear_w <= 1'b0;
        run_for(24100);
        held = value;
        check(near(held, 6025), "long count wrong");
        for (int b = 0; b < 4; b++) begin
            base_w <= ets_base_t'(b);
            step(4);
            check(value === scaled(held, ets_base_t'(b)), "time base scaling");
        end
        finish_test();
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule

// *** test/ets_ctrl_model.sv ***
// Model of the control logic that feeds the stopwatch inputs.
`timescale 1ns/100ps
module ets_ctrl_model (
    // Clock
    input  wire logic               clock_in,
    // Wanted levels from the bench
    input  wire logic               run_in,
    input  wire logic               split_in,
    input  wire logic               clear_in,
    input  wire ets_pkg::ets_base_t base_in,
    // Levels to the stopwatch
    output logic                    run_out   = 1'b0,
    output logic                    split_out = 1'b0,
    output logic                    clear_out = 1'b0,
    output ets_pkg::ets_base_t      base_out  = ets_pkg::ETS_HUNDREDTHS
);
    import ets_pkg::*;
    // ==========================================
    // Program logic updates once per cycle, away from the sampling edge.
    always @(negedge clock_in) begin
        run_out   <= run_in;
        split_out <= split_in;
        clear_out <= clear_in;
        base_out  <= base_in;
    end
endmodule
